/* File: hdl/wrc_pkg.sv */
// constants and types for the watchdog and reset control block
// What this block does
// - watchdog counts only while key field holds 10101B or 01010B
// - any other key gives full reset after soft delay, sets key fault
// - key field is 01010B after power-on, watchdog enabled
// - period select picks 2^8,10,12,14,15,16,17,18 sub clock ticks
// - key fault flag set by hardware, cleared only by software zero
// - overflow in fast or slow run gives full reset, sets time-out flag
// - overflow in sleep or idle sets time-out, resets only pc and sp
// - counter cleared by key fault, clear instruction or halt
// - power-on clears pc and puts every port pin into input
// - power-on holds reset for the 48 ms power-on delay
// - low-voltage reset only after low supply outlasts filter time
// - threshold select accepts only 55h, 33h, 99h and aah
// - bad threshold code: reset after soft delay, flag, reload 55h
// - genuine low-voltage reset keeps threshold select unchanged
// - low-voltage reset disabled in sleep or idle
// - low-voltage flag set by hardware, cleared only by software zero
// - threshold fault flag set by hardware, cleared only by software
// - watchdog full reset acts like low-voltage one but reloads 55h threshold, 16 ms start-up
// - flag register bits 6 and 3 always read zero
// - watchdog counter advances on the slow sub clock tick
// - watchdog control reloads 53h on every reset but warm one
package wrc_pkg;

    // core clock and timing figures
    localparam int CLK_MHZ = 100;
    localparam int POR_DELAY_MS = 48;
    localparam int POR_DELAY_CYC = POR_DELAY_MS * CLK_MHZ * 1000;
    localparam int WDT_START_MS = 16;
    localparam int WDT_START_CYC = WDT_START_MS * CLK_MHZ * 1000;
    localparam int SRESET_US = 20;
    localparam int SRESET_CYC = SRESET_US * CLK_MHZ;
    localparam int LVR_FILTER_US = 40;
    localparam int LVR_FILTER_CYC = LVR_FILTER_US * CLK_MHZ;

    // counter widths
    localparam int HOLD_W = 23;
    localparam int SOFT_W = 12;
    localparam int LOW_VOLTAGE_RESET_FLAG_W = 12;
    localparam int WCNT_W = 18;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_WATCHDOG_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_LOW_VOLTAGE_THRESHOLD_SELECT = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;

    // field positions and reset values
    localparam int KEY_LSB = 3;
    localparam logic [4:0] KEY_A = 5'h15;
    localparam logic [4:0] KEY_B = 5'h0a;
    localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h53;
    localparam logic [7:0] LOW_VOLTAGE_THRESHOLD_SELECT_RESET = 8'h55;
    localparam logic [7:0] THR_2V10 = 8'h55;
    localparam logic [7:0] THR_2V55 = 8'h33;
    localparam logic [7:0] THR_3V15 = 8'h99;
    localparam logic [7:0] THR_3V80 = 8'haa;
    localparam logic [7:0] CTRL_PLAIN_MASK = 8'hb0;
    localparam int CTRL_WRF = 0;
    localparam int CTRL_LRF = 1;
    localparam int CTRL_LOW_VOLTAGE_RESET_FLAG = 2;
    localparam int STAT_TO = 0;
    localparam int STAT_SOFT = 1;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SOFT = 3'b010,
        ST_HOLD = 3'b100
    } wrc_state_e;

endpackage

/* File: hdl/wrc_top.sv */
// watchdog timer and reset sequencer with apb register access
`timescale 1ns/1ps
module wrc_top #(
    parameter int POR_CYCLES = wrc_pkg::POR_DELAY_CYC,
    parameter int WDT_START_CYCLES = wrc_pkg::WDT_START_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core and supply side
    input wire logic subTick,
    input wire logic lowSupply,
    input wire logic lowPowerMode,
    input wire logic wdtClearInstr,
    input wire logic haltInstr,
    // reset outputs
    output logic sysResetn,
    output logic pcSpReset,
    output logic powerOnReset,
    output logic portsAsInput,
    output logic timeoutFlag,
    output logic [7:0] thresholdSelect
);

    wrc_pkg::wrc_state_e state;
    wrc_pkg::wrc_state_e next_state;
    logic [7:0] wdtCtl;
    logic [2:0] ctrlPlain;
    logic keyFaultFlag;
    logic thrFaultFlag;
    logic lvrFlag;
    logic [wrc_pkg::WCNT_W-1:0] wdtCnt;
    logic [wrc_pkg::HOLD_W-1:0] holdCnt;
    logic [wrc_pkg::SOFT_W-1:0] softCnt;
    logic [wrc_pkg::LOW_VOLTAGE_RESET_FLAG_W-1:0] lvrCnt;
    logic holdShort;

    // key field holds one of the two enable patterns
    function automatic logic wrc_key_ok(input logic [7:0] ctl);
        return (ctl[7:wrc_pkg::KEY_LSB] == wrc_pkg::KEY_A) ||
            (ctl[7:wrc_pkg::KEY_LSB] == wrc_pkg::KEY_B);
    endfunction

    // threshold code is one of the four defined levels
    function automatic logic wrc_thr_ok(input logic [7:0] thr);
        return (thr == wrc_pkg::THR_2V10) || (thr == wrc_pkg::THR_2V55) ||
            (thr == wrc_pkg::THR_3V15) || (thr == wrc_pkg::THR_3V80);
    endfunction

    // low bits that must all be set for an overflow at this period
    function automatic logic [wrc_pkg::WCNT_W-1:0] wrc_period_mask(
        input logic [2:0] sel);
        case (sel)
            3'h0: return 18'h000ff;
            3'h1: return 18'h003ff;
            3'h2: return 18'h00fff;
            3'h3: return 18'h03fff;
            3'h4: return 18'h07fff;
            3'h5: return 18'h0ffff;
            3'h6: return 18'h1ffff;
            default: return 18'h3ffff;
        endcase
    endfunction

    // decoded state of the control registers
    wire keyOk = wrc_key_ok(wdtCtl);
    wire thrOk = wrc_thr_ok(thresholdSelect);
    wire softFault = !keyOk || !thrOk;
    wire [wrc_pkg::WCNT_W-1:0] periodMask =
        wrc_period_mask(wdtCtl[2:0]);
    wire inRun = (state == wrc_pkg::ST_RUN);
    wire inSoft = (state == wrc_pkg::ST_SOFT);
    wire inHold = (state == wrc_pkg::ST_HOLD);

    // watchdog overflow: all selected low bits set at a sub clock tick;
    // a clear or halt in that same cycle restarts the count instead
    wire wdtOvf = inRun && keyOk && subTick &&
        !wdtClearInstr && !haltInstr && (&(wdtCnt | ~periodMask));
    wire wdtFull = wdtOvf && !lowPowerMode;
    wire wdtWarm = wdtOvf && lowPowerMode;

    // low supply must be seen longer than the filter time
    wire lvrArmed = lowSupply && !lowPowerMode && !inHold;
    wire lvrHit = lvrArmed &&
        (lvrCnt == wrc_pkg::LOW_VOLTAGE_RESET_FLAG_W'(wrc_pkg::LVR_FILTER_CYC));

    // bad key or bad threshold fires after the soft-reset delay
    wire softDone = inSoft &&
        (softCnt == wrc_pkg::SOFT_W'(wrc_pkg::SRESET_CYC - 1));
    wire keyFaultHit = softDone && !keyOk;
    wire thrFaultHit = softDone && !thrOk;

    // every full reset cause funnels into the same hold sequence
    wire enterHold = lvrHit || softDone || wdtFull;
    wire shortHold = wdtFull && !lvrHit && !softDone;
    wire [wrc_pkg::HOLD_W-1:0] holdLimit = holdShort ?
        wrc_pkg::HOLD_W'(WDT_START_CYCLES - 1) :
        wrc_pkg::HOLD_W'(POR_CYCLES - 1);
    wire holdDone = inHold && (holdCnt == holdLimit);

    // counter is held at zero by a key fault, clear or halt
    wire wdtZero = !inRun || !keyOk || wdtClearInstr || haltInstr ||
        wdtOvf;

    // apb phases; the registered read path is loaded during setup,
    // so every transfer completes in its first access cycle with no wait cycle
    wire setupPh = psel && !penable;
    wire accessPh = psel && penable && pready;
    wire regWrite = accessPh && pwrite && !inHold;
    wire selWdtc = (paddr == wrc_pkg::OFS_WATCHDOG_CONTROL);
    wire selCtrl = (paddr == wrc_pkg::OFS_CTRL);
    wire selLvrc = (paddr == wrc_pkg::OFS_LOW_VOLTAGE_THRESHOLD_SELECT);
    wire selStat = (paddr == wrc_pkg::OFS_STAT);
    wire mapped = selWdtc || selCtrl || selLvrc || selStat;
    wire wrWdtc = regWrite && selWdtc;
    wire wrCtrl = regWrite && selCtrl;
    wire wrLvrc = regWrite && selLvrc;

    // software may only clear the sticky flags by writing zero
    wire clrWrf = wrCtrl && !pwdata[wrc_pkg::CTRL_WRF];
    wire clrLrf = wrCtrl && !pwdata[wrc_pkg::CTRL_LRF];
    wire clrLvrf = wrCtrl && !pwdata[wrc_pkg::CTRL_LOW_VOLTAGE_RESET_FLAG];

    // set wins over a clear landing in the same cycle
    wire next_keyFaultFlag = keyFaultHit || (keyFaultFlag && !clrWrf);
    wire next_thrFaultFlag = thrFaultHit || (thrFaultFlag && !clrLrf);
    wire next_lvrFlag = lvrHit || (lvrFlag && !clrLvrf);
    wire next_timeoutFlag = wdtOvf ||
        (timeoutFlag && !wdtClearInstr && !haltInstr);

    // flag register image; bits 6 and 3 are unimplemented
    wire [7:0] ctrlImage = {ctrlPlain[2], 1'b0, ctrlPlain[1:0], 1'b0,
        lvrFlag, thrFaultFlag, keyFaultFlag};
    wire [7:0] statImage = {6'h00, inSoft, timeoutFlag};
    wire [7:0] readByte = selWdtc ? wdtCtl :
        selCtrl ? ctrlImage :
        selLvrc ? thresholdSelect :
        selStat ? statImage : 8'h00;

    // next reset sequencer state
    always_comb
    begin
        case (state)
            wrc_pkg::ST_RUN:
            begin
                if (enterHold)
                    next_state = wrc_pkg::ST_HOLD;
                else if (softFault)
                    next_state = wrc_pkg::ST_SOFT;
                else
                    next_state = wrc_pkg::ST_RUN;
            end
            wrc_pkg::ST_SOFT:
            begin
                if (enterHold)
                    next_state = wrc_pkg::ST_HOLD;
                else
                    next_state = wrc_pkg::ST_SOFT;
            end
            wrc_pkg::ST_HOLD:
            begin
                if (holdDone)
                    next_state = wrc_pkg::ST_RUN;
                else
                    next_state = wrc_pkg::ST_HOLD;
            end
            default:
                next_state = wrc_pkg::ST_RUN;
        endcase
    end

    // state and hold length; power-on enters the long hold
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            state <= wrc_pkg::ST_HOLD;
            holdShort <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (enterHold)
                holdShort <= shortHold;
        end
    end

    // hold, soft delay and supply filter counters
    always_ff @(posedge core_clk)
    begin
        if (!rstn || !inHold)
            holdCnt <= '0;
        else
            holdCnt <= holdCnt + 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn || !inSoft)
            softCnt <= '0;
        else
            softCnt <= softCnt + 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn || !lvrArmed)
            lvrCnt <= '0;
        else
            lvrCnt <= lvrCnt + 1'b1;
    end

    // watchdog counter on the sub clock tick
    always_ff @(posedge core_clk)
    begin
        if (!rstn || wdtZero)
            wdtCnt <= '0;
        else if (subTick)
            wdtCnt <= wdtCnt + 1'b1;
    end

    // watchdog control: power-on key is enabled, any full reset reloads
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            wdtCtl <= wrc_pkg::WATCHDOG_CONTROL_RESET;
        else if (enterHold)
            wdtCtl <= wrc_pkg::WATCHDOG_CONTROL_RESET;
        else if (wrWdtc)
            wdtCtl <= pwdata[7:0];
    end

    // threshold select: reload on bad code or watchdog, not on real lvr
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            thresholdSelect <= wrc_pkg::LOW_VOLTAGE_THRESHOLD_SELECT_RESET;
        else if (thrFaultHit || wdtFull)
            thresholdSelect <= wrc_pkg::LOW_VOLTAGE_THRESHOLD_SELECT_RESET;
        else if (wrLvrc)
            thresholdSelect <= pwdata[7:0];
    end

    // key fault flag; only its own cause sets it
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            keyFaultFlag <= 1'b0;
        else
            keyFaultFlag <= next_keyFaultFlag;
    end

    // threshold fault flag
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            thrFaultFlag <= 1'b0;
        else
            thrFaultFlag <= next_thrFaultFlag;
    end

    // low-voltage flag
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            lvrFlag <= 1'b0;
        else
            lvrFlag <= next_lvrFlag;
    end

    // time-out flag survives a warm reset so software can see the cause
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            timeoutFlag <= 1'b0;
        else
            timeoutFlag <= next_timeoutFlag;
    end

    // plain storage bits of the flag register
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            ctrlPlain <= 3'h0;
        else if (wrCtrl)
            ctrlPlain <= {pwdata[7], pwdata[5:4]};
    end

    // system reset, registered from the next state
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            sysResetn <= 1'b0;
        else
            sysResetn <= (next_state != wrc_pkg::ST_HOLD);
    end

    // pc and sp reset: whole hold, or one cycle on a warm overflow
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            pcSpReset <= 1'b1;
        else
            pcSpReset <= (next_state == wrc_pkg::ST_HOLD) || wdtWarm;
    end

    // ports as inputs for as long as the full reset is held
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            portsAsInput <= 1'b1;
        else
            portsAsInput <= (next_state == wrc_pkg::ST_HOLD);
    end

    // power-on marker, cleared once the first hold has run out
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            powerOnReset <= 1'b1;
        else
            powerOnReset <= powerOnReset && !holdDone;
    end

    // apb slave: answer registered in setup, completes in access
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= setupPh;
            pslverr <= setupPh && !mapped;
            prdata <= setupPh ? {24'h000000, readByte} : 32'h00000000;
        end
    end

endmodule // wrc_top

/* File: verification/wrc_top_properties.sv */
// assertion checker bound to the watchdog and reset control top
`timescale 1ns/1ps
module wrc_checker #(
    parameter int POR_CYCLES = 20,
    parameter int WDT_START_CYCLES = 10
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic subTick,
    input wire logic lowSupply,
    input wire logic lowPowerMode,
    input wire logic wdtClearInstr,
    input wire logic haltInstr,
    input wire logic sysResetn,
    input wire logic pcSpReset,
    input wire logic powerOnReset,
    input wire logic portsAsInput,
    input wire logic timeoutFlag,
    input wire logic [7:0] thresholdSelect
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    int lowCnt;
    int porCnt;
    // run of low supply outside sleep, and length of the power-on hold
    always_ff @(posedge core_clk)
    begin
        lowCnt <= (lowSupply && !lowPowerMode && sysResetn) ? lowCnt + 1 : 0;
        porCnt <= sysResetn ? 0 : porCnt + (powerOnReset ? 1 : 0);
    end
    sequence setupS;
        psel && !penable;
    endsequence
    sequence accessS;
        psel && penable && pready;
    endsequence
    chk_one_wait: assert property (setupS |=> pready)
        else $error("ready not one cycle after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_unmapped_err: assert property
        (accessS ##0 (paddr >= 8'h10) |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_gap_bits: assert property (
        accessS ##0 (paddr == 8'h04) |-> !prdata[6] && !prdata[3])
        else $error("unused flag bits read high");
    chk_low_supply_fires: assert property (
        lowCnt == 4001 |-> ##[0:2] !sysResetn)
        else $error("long low supply gave no reset");
    chk_warm_flag: assert property (
        pcSpReset && sysResetn |-> ##[0:1] timeoutFlag)
        else $error("warm reset without time-out flag");
    chk_warm_no_full: assert property (
        pcSpReset && sysResetn |=> sysResetn)
        else $error("warm reset became full reset");
    chk_full_holds: assert property (
        !sysResetn |-> portsAsInput && pcSpReset)
        else $error("ports or pc not held in reset");
    chk_por_len: assert property (
        $rose(sysResetn) && porCnt > 0 |-> porCnt >= POR_CYCLES - 1)
        else $error("power-on hold too short");
    chk_flag_cleared: assert property (
        wdtClearInstr || haltInstr |=> !timeoutFlag)
        else $error("clear left time-out flag set");
    chk_thr_legal: assert property (
        $rose(sysResetn) |->
        thresholdSelect inside {8'h55, 8'h33, 8'h99, 8'haa})
        else $error("illegal threshold after reset");
endmodule // wrc_checker
bind wrc_top wrc_checker #(
    .POR_CYCLES(POR_CYCLES),
    .WDT_START_CYCLES(WDT_START_CYCLES)
) chk (
    .core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .subTick, .lowSupply, .lowPowerMode, .wdtClearInstr,
    .haltInstr, .sysResetn, .pcSpReset, .powerOnReset, .portsAsInput,
    .timeoutFlag, .thresholdSelect
);

/* File: verification/tb_watchdog_and_reset_control.sv */
// self-checking bench for the watchdog and reset control block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
 $display("wrong value at %0t got %h expected %h", $time, a, b); end end
module tb_watchdog_and_reset_control;
    logic core_clk, rstn, psel, penable, pwrite, subTick, lowSupply;
    logic lowPowerMode, wdtClearInstr, haltInstr, pready, pslverr, err;
    logic sysResetn, pcSpReset, powerOnReset, portsAsInput, timeoutFlag;
    logic [7:0] paddr, thresholdSelect, seed, mW, mC, mL;
    logic [31:0] pwdata, prdata, rdv;
    logic [7:0] thr[4] = '{8'haa, 8'h99, 8'h33, 8'h55};
    int fail_count = 0;
    int tests_run = 0;
    wrc_top #(.POR_CYCLES(20), .WDT_START_CYCLES(10)) dut (
        .core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .subTick, .lowSupply, .lowPowerMode,
        .wdtClearInstr, .haltInstr, .sysResetn, .pcSpReset, .powerOnReset,
        .portsAsInput, .timeoutFlag, .thresholdSelect
    );
    // free-running core clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // one transfer; holds the request until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(rdv, {24'h0, e})
    endtask
    // sub clock ticks with random gaps, so overflow counts ticks not cycles
    task automatic tick(input int n);
        repeat (n)
        begin
            seed = nx(seed);
            @(posedge core_clk);
            subTick <= 1'b1;
            @(posedge core_clk);
            subTick <= 1'b0;
            repeat (seed[1:0]) @(posedge core_clk);
        end
    endtask
    task automatic pulse(input logic h);
        @(posedge core_clk);
        haltInstr <= h;
        wdtClearInstr <= !h;
        @(posedge core_clk);
        haltInstr <= 1'b0;
        wdtClearInstr <= 1'b0;
        @(posedge core_clk);
    endtask
    // bounded wait for one full reset to start and end
    task automatic rstWait();
        repeat (9000) if (sysResetn !== 1'b0) @(posedge core_clk);
        `CHK(sysResetn, 1'b0)
        repeat (200) if (sysResetn !== 1'b1) @(posedge core_clk);
        `CHK(sysResetn, 1'b1)
        mW = 8'h53;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard, well above the expected run length
    initial
    begin
        repeat (100000) @(posedge core_clk);
        fail_count++;
        give_verdict();
    end
    initial
    begin
        {rstn, psel, penable, pwrite, subTick, lowSupply} = '0;
        {lowPowerMode, wdtClearInstr, haltInstr} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        seed = 8'h1c;
        mW = 8'h53;
        mC = 8'h00;
        mL = 8'h55;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (100) if (sysResetn !== 1'b1) @(posedge core_clk);
        rd(8'h00, mW);
        rd(8'h08, mL);
        rd(8'h04, mC);
        apb(1'b0, 8'h10, 8'h00);
        `CHK(err, 1'b1)
        apb(1'b1, 8'h04, 8'hff);
        rd(8'h04, 8'hb0);
        apb(1'b1, 8'h04, 8'h00);
        foreach (thr[i])
        begin
            apb(1'b1, 8'h08, thr[i]);
            rd(8'h08, thr[i]);
        end
        // full-run overflow at period code 1
        apb(1'b1, 8'h00, 8'h51);
        tick(1023);
        repeat (3) @(posedge core_clk);
        `CHK(sysResetn, 1'b1)
        tick(1);
        rstWait();
        `CHK(timeoutFlag, 1'b1)
        rd(8'h00, mW);
        pulse(1'b0);
        `CHK(timeoutFlag, 1'b0)
        // sleep overflow at period code 0, halt restarts the count
        apb(1'b1, 8'h00, 8'ha8);
        lowPowerMode <= 1'b1;
        tick(200);
        pulse(1'b1);
        tick(255);
        `CHK(timeoutFlag, 1'b0)
        tick(1);
        repeat (3) @(posedge core_clk);
        `CHK(timeoutFlag, 1'b1)
        `CHK(sysResetn, 1'b1)
        rd(8'h00, 8'ha8);
        pulse(1'b0);
        lowPowerMode <= 1'b0;
        // bad key, then bad threshold code
        apb(1'b1, 8'h00, 8'h00);
        rstWait();
        mC = mC | 8'h01;
        rd(8'h04, mC);
        rd(8'h00, mW);
        apb(1'b1, 8'h08, 8'h12);
        rstWait();
        mC = mC | 8'h02;
        rd(8'h04, mC);
        rd(8'h08, mL);
        apb(1'b1, 8'h04, 8'h00);
        mC = 8'h00;
        rd(8'h04, mC);
        // short dip, dip in sleep, then a real low supply
        apb(1'b1, 8'h08, 8'h99);
        mL = 8'h99;
        lowSupply <= 1'b1;
        repeat (3000) @(posedge core_clk);
        lowSupply <= 1'b0;
        @(posedge core_clk);
        lowPowerMode <= 1'b1;
        lowSupply <= 1'b1;
        repeat (5000) @(posedge core_clk);
        `CHK(sysResetn, 1'b1)
        lowPowerMode <= 1'b0;
        rstWait();
        lowSupply <= 1'b0;
        mC = mC | 8'h04;
        rd(8'h04, mC);
        rd(8'h08, mL);
        `CHK(thresholdSelect, mL)
        // power-on again in mid-run: long hold, every cause forgotten
        rstn <= 1'b0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (18) @(posedge core_clk);
        `CHK(powerOnReset, 1'b1)
        `CHK(portsAsInput, 1'b1)
        `CHK(pcSpReset, 1'b1)
        rstWait();
        `CHK(powerOnReset, 1'b0)
        mC = 8'h00;
        mL = 8'h55;
        rd(8'h04, mC);
        rd(8'h08, mL);
        rd(8'h00, mW);
        give_verdict();
    end
endmodule // tb_watchdog_and_reset_control
